// ### bwm_top.sv
// breaker wear monitor: remaining operations, alarms, events, record log, APB registers
// Notes on behaviour
// [R01] alarm 1 on while any phase's remaining count is below the alarm 1 threshold
// [R02] alarm 2 on while any phase's remaining count is below the alarm 2 threshold
// [R03] condition reads normal, alarm 1 active or alarm 2 active
// [R04] resettable counters of opens, alarm 1 and alarm 2 occurrences, one per occurrence
// [R05] each phase keeps its own readable remaining count
// [R06] events: triggered, alarm 1 on/off, alarm 2 on/off
// [R07] selection passes ON events, OFF events or both to the event outputs
// [R08] every event carries a millisecond time stamp
// [R09] log keeps the twelve most recent records
// [R10] only ON events write a record, capturing process data
// [R11] record: time, event, trigger currents, deducted and remaining per phase
// [R12] alarm and trigger levels are direct outputs
// [R13] breaker open command starts a calculation, sampling all three currents
// [R14] each deduction subtracts cumulatively from that phase's remaining count
// [R15] each alarm level can be disabled; disabled never asserts
// [R16] a full log overwrites its oldest record
// [R17] alarm clears with OFF event once all phases are back at or above threshold
`timescale 1ns/10ps
module bwm_top
  import bwm_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              open_cmd,
  input  wire logic [CUR_W-1:0]  cur_phase_a,
  input  wire logic [CUR_W-1:0]  cur_phase_b,
  input  wire logic [CUR_W-1:0]  cur_phase_c,
  input  wire logic [OPS_W-1:0]  ded_phase_a,
  input  wire logic [OPS_W-1:0]  ded_phase_b,
  input  wire logic [OPS_W-1:0]  ded_phase_c,
  output logic                   alarm1,
  output logic                   alarm2,
  output logic                   trig_out,
  output logic                   evt_trig,
  output logic                   evt_a1_on,
  output logic                   evt_a1_off,
  output logic                   evt_a2_on,
  output logic                   evt_a2_off,
  output logic      [TIME_W-1:0] evt_time,
  output logic                   irq
);
  logic [3:0]        ctrl;
  logic [OPS_W-1:0]  start_ops, a1_set, a2_set;
  logic [OPS_W-1:0]  left [3];
  logic [OPS_W-1:0]  ded_q [3];
  logic [CUR_W-1:0]  cur_q [3];
  logic [31:0]       open_cnt, a1_cnt, a2_cnt;
  logic [IRQ_W-1:0]  irq_stat, irq_mask;
  logic [TIME_W-1:0] now_ms;
  logic [31:0]       div_cnt;
  logic [3:0]        log_sel;
  logic [2:0]        pend;
  logic              open_s1, open_s2, open_s3;

  // apb decode; writes take effect on the edge that completes the access
  wire        acc      = psel & penable;
  wire        wr_en    = acc & pready & pwrite;
  wire        wr_ctrl  = wr_en & (paddr == OFF_CTRL);
  wire        cnt_clr  = wr_ctrl & pwdata[CTRL_CNT_CLR];
  wire        reload   = wr_ctrl & pwdata[CTRL_RELOAD];
  wire        sel_on   = ctrl[CTRL_SEL_ON];
  wire        sel_off  = ctrl[CTRL_SEL_OFF];
  wire [7:0]  log_off  = paddr - OFF_LOG_BASE;
  wire        log_hit  = (paddr >= OFF_LOG_BASE) && (log_off < 8'(4 * LOG_WORDS)) && (paddr[1:0] == 2'h0);
  wire        ms_tick  = (div_cnt == 32'(MS_DIV - 1));

  // rising edge of the synchronised open command starts a calculation
  wire trig = open_s2 & ~open_s3; // [R13]

  function automatic logic any_below(input logic [OPS_W-1:0] a, b, c, thr);
    return (a < thr) || (b < thr) || (c < thr);
  endfunction : any_below

  function automatic logic [OPS_W-1:0] sat_sub(input logic [OPS_W-1:0] v, d);
    return (d > v) ? '0 : v - d;
  endfunction : sat_sub

  wire next_alarm1 = ctrl[CTRL_A1_EN] & any_below(left[0], left[1], left[2], a1_set); // [R01] [R15] [R17]
  wire next_alarm2 = ctrl[CTRL_A2_EN] & any_below(left[0], left[1], left[2], a2_set); // [R02] [R15] [R17]
  wire a1_on  = next_alarm1 & ~alarm1;
  wire a1_off = ~next_alarm1 & alarm1;
  wire a2_on  = next_alarm2 & ~alarm2;
  wire a2_off = ~next_alarm2 & alarm2;
  wire [1:0] cond = alarm2 ? COND_A2 : (alarm1 ? COND_A1 : COND_NORMAL); // [R03]

  wire [IRQ_W-1:0] ev_vec = {a2_off, a2_on, a1_off, a1_on, trig};
  wire [IRQ_W-1:0] irq_clr = (wr_en && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | ev_vec;
  // a mask written in this cycle already counts, so irq never lags the register pair
  wire [IRQ_W-1:0] next_irq_mask = (wr_en && paddr == OFF_IRQ_MASK) ? pwdata[IRQ_W-1:0] : irq_mask;

  // one record per cycle; simultaneous ON events wait in pend, trigger first
  wire [2:0] new_on = {a2_on, a1_on, trig}; // [R10]
  wire [2:0] grant  = pend[0] ? 3'h1 : (pend[1] ? 3'h2 : (pend[2] ? 3'h4 : 3'h0));
  wire [2:0] next_pend = (pend & ~grant) | new_on;
  wire       log_wr = |grant;
  wire [1:0] log_ev = grant[0] ? EV_TRIG : (grant[1] ? EV_A1_ON : EV_A2_ON);
  wire [REC_W-1:0] log_wdata = {now_ms, log_ev, cur_q[0], cur_q[1], cur_q[2],
                                ded_q[0], ded_q[1], ded_q[2], left[0], left[1], left[2]}; // [R11] [R08]
  wire [REC_W-1:0] log_rdata;
  wire [3:0]       log_cnt;

  bwm_log #(
    .DEPTH (LOG_DEPTH),
    .W     (REC_W)
  ) u_log (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (log_wr),
    .wdata   (log_wdata),
    .rd_idx  (log_sel),
    .rdata   (log_rdata),
    .count   (log_cnt)
  );

  // log words from the top: time, event, currents a..c, deducted a..c, left a..c
  wire [3:0]  log_word = log_off[5:2];
  wire [31:0] log_word_data =
    (log_word == 4'h0) ? log_rdata[REC_W-1 -: TIME_W] :
    (log_word == 4'h1) ? 32'(log_rdata[REC_W-TIME_W-1 -: 2]) :
    (log_word <= 4'h4) ? 32'(log_rdata[6*OPS_W + (4-log_word)*CUR_W +: CUR_W]) :
    (log_word <= 4'h7) ? 32'(log_rdata[3*OPS_W + (7-log_word)*OPS_W +: OPS_W]) :
                         32'(log_rdata[(10-log_word)*OPS_W +: OPS_W]);

  wire        reg_hit = (paddr <= OFF_LOG_CNT) && (paddr[1:0] == 2'h0);
  wire [31:0] reg_data =
    (paddr == OFF_CTRL)     ? 32'(ctrl) :
    (paddr == OFF_START)    ? 32'(start_ops) :
    (paddr == OFF_A1_SET)   ? 32'(a1_set) :
    (paddr == OFF_A2_SET)   ? 32'(a2_set) :
    (paddr == OFF_STATUS)   ? {27'h0, trig_out, alarm2, alarm1, cond} :
    (paddr == OFF_OPEN_CNT) ? open_cnt :
    (paddr == OFF_A1_CNT)   ? a1_cnt :
    (paddr == OFF_A2_CNT)   ? a2_cnt :
    (paddr == OFF_LEFT_A)   ? 32'(left[0]) : // [R05]
    (paddr == OFF_LEFT_B)   ? 32'(left[1]) :
    (paddr == OFF_LEFT_C)   ? 32'(left[2]) :
    (paddr == OFF_IRQ_STAT) ? 32'(irq_stat) :
    (paddr == OFF_IRQ_MASK) ? 32'(irq_mask) :
    (paddr == OFF_TIME)     ? now_ms :
    (paddr == OFF_LOG_SEL)  ? 32'(log_sel) :
                              32'(log_cnt);
  wire [31:0] next_prdata = log_hit ? log_word_data : (reg_hit ? reg_data : 32'h0);

  // one wait state: pready rises the cycle after penable
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~(reg_hit | log_hit);
      prdata  <= (acc & ~pready & ~pwrite) ? next_prdata : 32'h0;
    end

  // settings
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl      <= CTRL_RST;
      start_ops <= START_RST;
      a1_set    <= A1_SET_RST;
      a2_set    <= A2_SET_RST;
      irq_mask  <= '0;
      log_sel   <= 4'h0;
    end
    else if (wr_en)
    begin
      if (paddr == OFF_CTRL)     ctrl      <= pwdata[3:0];
      if (paddr == OFF_START)    start_ops <= pwdata[OPS_W-1:0];
      if (paddr == OFF_A1_SET)   a1_set    <= pwdata[OPS_W-1:0];
      if (paddr == OFF_A2_SET)   a2_set    <= pwdata[OPS_W-1:0];
      if (paddr == OFF_IRQ_MASK) irq_mask  <= pwdata[IRQ_W-1:0];
      if (paddr == OFF_LOG_SEL)  log_sel   <= pwdata[3:0];
    end

  // millisecond time base; software may preset the clock
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      div_cnt <= 32'h0;
      now_ms  <= '0;
    end
    else
    begin
      div_cnt <= ms_tick ? 32'h0 : div_cnt + 32'h1;
      if (wr_en && paddr == OFF_TIME)
        now_ms <= pwdata;
      else if (ms_tick)
        now_ms <= now_ms + 32'h1;
    end

  // open command is a pin: two flops before any logic
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      open_s1 <= 1'b0;
      open_s2 <= 1'b0;
      open_s3 <= 1'b0;
    end
    else
    begin
      open_s1 <= open_cmd;
      open_s2 <= open_s1;
      open_s3 <= open_s2;
    end

  // per-phase remaining count, trigger data capture
  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    wire [CUR_W-1:0] cur_in = (p == 0) ? cur_phase_a : ((p == 1) ? cur_phase_b : cur_phase_c);
    wire [OPS_W-1:0] ded_in = (p == 0) ? ded_phase_a : ((p == 1) ? ded_phase_b : ded_phase_c);
    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
        left[p]  <= START_RST;
        cur_q[p] <= '0;
        ded_q[p] <= '0;
      end
      else if (reload)
        left[p] <= start_ops; // [R17]
      else if (trig)
      begin
        left[p]  <= sat_sub(left[p], ded_in); // [R14]
        cur_q[p] <= cur_in;                   // [R13]
        ded_q[p] <= ded_in;
      end
  end

  // counters clear first, so an occurrence in the clearing cycle still counts
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      open_cnt <= 32'h0;
      a1_cnt   <= 32'h0;
      a2_cnt   <= 32'h0;
    end
    else
    begin
      open_cnt <= (cnt_clr ? 32'h0 : open_cnt) + 32'(trig);  // [R04]
      a1_cnt   <= (cnt_clr ? 32'h0 : a1_cnt) + 32'(a1_on);   // [R04]
      a2_cnt   <= (cnt_clr ? 32'h0 : a2_cnt) + 32'(a2_on);   // [R04]
    end

  // alarm levels, direct outputs, events and interrupt
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      alarm1     <= 1'b0;
      alarm2     <= 1'b0;
      trig_out   <= 1'b0;
      evt_trig   <= 1'b0;
      evt_a1_on  <= 1'b0;
      evt_a1_off <= 1'b0;
      evt_a2_on  <= 1'b0;
      evt_a2_off <= 1'b0;
      evt_time   <= '0;
      irq_stat   <= '0;
      irq        <= 1'b0;
      pend       <= 3'h0;
    end
    else
    begin
      alarm1     <= next_alarm1;         // [R01] [R12]
      alarm2     <= next_alarm2;         // [R02] [R12]
      trig_out   <= trig;                // [R12]
      evt_trig   <= trig & sel_on;       // [R06] [R07]
      evt_a1_on  <= a1_on & sel_on;      // [R06] [R07]
      evt_a1_off <= a1_off & sel_off;    // [R06] [R07] [R17]
      evt_a2_on  <= a2_on & sel_on;      // [R06] [R07]
      evt_a2_off <= a2_off & sel_off;    // [R06] [R07] [R17]
      evt_time   <= now_ms;              // [R08]
      irq_stat   <= next_irq_stat;
      irq        <= |(next_irq_stat & next_irq_mask);
      pend       <= next_pend;           // [R10]
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_alarm1_cause: assert property (alarm1 |-> $past(ctrl[CTRL_A1_EN]) &&
    $past(any_below(left[0], left[1], left[2], a1_set))) else $error("alarm 1 without cause"); // [R01]
  a_alarm2_cause: assert property ($rose(alarm2) |-> $past(left[0] < a2_set || left[1] < a2_set
    || left[2] < a2_set)) else $error("alarm 2 without low count"); // [R02]
  a_cond_code: assert property ((cond == COND_A2) == alarm2 && (cond == COND_A1) == (alarm1 && !alarm2))
    else $error("condition code wrong"); // [R03]
  a_open_count: assert property (trig && !cnt_clr |=> open_cnt == $past(open_cnt) + 32'h1)
    else $error("open counter missed"); // [R04]
  a_left_deduct: assert property (trig && !reload |=> left[0] == sat_sub($past(left[0]), $past(ded_phase_a)))
    else $error("phase a deduction wrong"); // [R14]
  a_trig_event: assert property (trig && sel_on |=> evt_trig && trig_out ##1 !evt_trig)
    else $error("trigger event not one pulse"); // [R06]
  a_off_filter: assert property (!sel_off |=> !evt_a1_off && !evt_a2_off)
    else $error("off event passed while deselected"); // [R07]
  a_disabled_quiet: assert property (!ctrl[CTRL_A2_EN] |=> !alarm2)
    else $error("disabled alarm 2 asserted"); // [R15]
  a_on_logged: assert property (a1_on |-> ##[1:3] (log_wr && log_ev == EV_A1_ON))
    else $error("alarm 1 record not written"); // [R10]
  a_off_release: assert property (alarm1 && !next_alarm1 && sel_off |=> !alarm1 && evt_a1_off)
    else $error("alarm 1 release missing"); // [R17]
  a_irq_level: assert property (irq == |(irq_stat & irq_mask)) else $error("irq level not following pending bits");

  c_trigger: cover property (trig ##[1:20] a1_on);
  c_both_on: cover property (a1_on && a2_on);
  c_release: cover property (alarm2 ##1 !alarm2);
  c_log_full: cover property (log_cnt == 4'(LOG_DEPTH) && log_wr);
endmodule : bwm_top

// ### bwm_pkg.sv
// shared constants of the breaker wear monitor
package bwm_pkg;
  localparam int OPS_W = 18;
  localparam int CUR_W = 16;
  localparam int TIME_W = 32;
  localparam int LOG_DEPTH = 12;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_START = 8'h04;
  localparam logic [7:0] OFF_A1_SET = 8'h08;
  localparam logic [7:0] OFF_A2_SET = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_OPEN_CNT = 8'h14;
  localparam logic [7:0] OFF_A1_CNT = 8'h18;
  localparam logic [7:0] OFF_A2_CNT = 8'h1C;
  localparam logic [7:0] OFF_LEFT_A = 8'h20;
  localparam logic [7:0] OFF_LEFT_B = 8'h24;
  localparam logic [7:0] OFF_LEFT_C = 8'h28;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFF_TIME = 8'h34;
  localparam logic [7:0] OFF_LOG_SEL = 8'h38;
  localparam logic [7:0] OFF_LOG_CNT = 8'h3C;
  localparam logic [7:0] OFF_LOG_BASE = 8'h40;
  localparam int LOG_WORDS = 11;
  // control bits
  localparam int CTRL_A1_EN = 0;
  localparam int CTRL_A2_EN = 1;
  localparam int CTRL_SEL_ON = 2;
  localparam int CTRL_SEL_OFF = 3;
  localparam int CTRL_CNT_CLR = 4;
  localparam int CTRL_RELOAD = 5;
  localparam logic [3:0] CTRL_RST = 4'hC;
  // interrupt status bits
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_A1_ON = 1;
  localparam int IRQ_A1_OFF = 2;
  localparam int IRQ_A2_ON = 3;
  localparam int IRQ_A2_OFF = 4;
  localparam int IRQ_W = 5;
  // reset values of settings
  localparam logic [OPS_W-1:0] START_RST = 18'h0C350;
  localparam logic [OPS_W-1:0] A1_SET_RST = 18'h003E8;
  localparam logic [OPS_W-1:0] A2_SET_RST = 18'h00064;
  // condition codes and logged event codes
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_A1 = 2'h1;
  localparam logic [1:0] COND_A2 = 2'h2;
  localparam logic [1:0] EV_TRIG = 2'h0;
  localparam logic [1:0] EV_A1_ON = 2'h1;
  localparam logic [1:0] EV_A2_ON = 2'h2;
  localparam int REC_W = TIME_W + 2 + 3 * CUR_W + 6 * OPS_W;
endpackage : bwm_pkg

// ### bwm_log.sv
// ring of the most recent operation records
`timescale 1ns/10ps
module bwm_log
  import bwm_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH,
  parameter int W     = REC_W
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  input  wire logic [3:0]   rd_idx,
  output logic      [W-1:0] rdata,
  output logic      [3:0]   count
);
  logic [W-1:0] mem [DEPTH];
  logic [3:0]   wptr;
  logic [4:0]   back;
  logic [3:0]   raddr;

  // index 0 is the newest record; the oldest is overwritten when full
  assign back  = 5'(wptr) + 5'(DEPTH) - 5'(rd_idx) - 5'h01;
  assign raddr = (back >= 5'(DEPTH)) ? 4'(back - 5'(DEPTH)) : back[3:0];
  assign rdata = (rd_idx < count) ? mem[raddr] : '0;

  always_ff @(posedge pclk)
    if (wr)
      mem[wptr] <= wdata;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wptr  <= 4'h0;
      count <= 4'h0;
    end
    else if (wr)
    begin
      wptr  <= (wptr == 4'(DEPTH - 1)) ? 4'h0 : wptr + 4'h1; // [R16]
      count <= (count == 4'(DEPTH)) ? count : count + 4'h1;  // [R09]
    end

  a_log_count_max: assert property (@(posedge pclk) disable iff (!presetn)
    count <= 4'(DEPTH)) else $error("log count above depth"); // [R09]
endmodule : bwm_log

// ### bwm_breaker.sv
// behavioural breaker: open command pin, phase currents and per-open deductions
`timescale 1ns/10ps
module bwm_breaker
  import bwm_pkg::*;
(
  input  wire logic             pclk,
  output logic                  open_cmd,
  output logic      [CUR_W-1:0] cur_phase_a,
  output logic      [CUR_W-1:0] cur_phase_b,
  output logic      [CUR_W-1:0] cur_phase_c,
  output logic      [OPS_W-1:0] ded_phase_a,
  output logic      [OPS_W-1:0] ded_phase_b,
  output logic      [OPS_W-1:0] ded_phase_c
);
  initial
  begin
    open_cmd = 1'b0;
    {cur_phase_a, cur_phase_b, cur_phase_c} = '0;
    {ded_phase_a, ded_phase_b, ded_phase_c} = '0;
  end

  // command held 4 cycles, deductions 7, then scrambled so a late sample shows
  task open_breaker(input logic [CUR_W-1:0] ca, cb, cc, input logic [OPS_W-1:0] da, db, dc);
    @(posedge pclk);
    cur_phase_a <= ca;
    cur_phase_b <= cb;
    cur_phase_c <= cc;
    {ded_phase_a, ded_phase_b, ded_phase_c} <= {da, db, dc};
    open_cmd <= 1'b1;
    repeat (4) @(posedge pclk);
    open_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    {ded_phase_a, ded_phase_b, ded_phase_c} <= ~{da, db, dc};
    repeat (4) @(posedge pclk);
  endtask : open_breaker
endmodule : bwm_breaker

// ### bwm_top_tb.sv
// self-checking bench of the breaker wear monitor over APB
`timescale 1ns/10ps
module bwm_top_tb
  import bwm_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, open_cmd;
  logic              alarm1, alarm2, trig_out, evt_trig, evt_a1_on, evt_a1_off, evt_a2_on, evt_a2_off, irq;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic [CUR_W-1:0]  cur_a, cur_b, cur_c;
  logic [OPS_W-1:0]  ded_a, ded_b, ded_c;
  logic [TIME_W-1:0] evt_time;
  logic [TIME_W-1:0] t_ev;
  int                n_fail, checks, i;
  int                n_ev [6];
  logic [7:0]        ra [10] = '{OFF_CTRL, OFF_START, OFF_A1_SET, OFF_A2_SET, OFF_STATUS, OFF_OPEN_CNT,
                                 OFF_LEFT_A, OFF_LEFT_B, OFF_LEFT_C, OFF_LOG_CNT};
  logic [31:0]       rv [10] = '{32'hC, 32'hC350, 32'h3E8, 32'h64, 32'h0, 32'h0,
                                 32'hC350, 32'hC350, 32'hC350, 32'h0};

  bwm_top #(.MS_DIV(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .open_cmd(open_cmd), .cur_phase_a(cur_a), .cur_phase_b(cur_b), .cur_phase_c(cur_c),
    .ded_phase_a(ded_a), .ded_phase_b(ded_b), .ded_phase_c(ded_c), .alarm1(alarm1), .alarm2(alarm2),
    .trig_out(trig_out), .evt_trig(evt_trig), .evt_a1_on(evt_a1_on), .evt_a1_off(evt_a1_off),
    .evt_a2_on(evt_a2_on), .evt_a2_off(evt_a2_off), .evt_time(evt_time), .irq(irq));

  bwm_breaker u_brk (.pclk(pclk), .open_cmd(open_cmd), .cur_phase_a(cur_a), .cur_phase_b(cur_b),
    .cur_phase_c(cur_c), .ded_phase_a(ded_a), .ded_phase_b(ded_b), .ded_phase_c(ded_c));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // pulse tallies: trig_out, evt_trig, a1 on, a1 off, a2 on, a2 off
  always @(posedge pclk)
  begin
    n_ev[0] += (trig_out === 1'b1);
    n_ev[1] += (evt_trig === 1'b1);
    n_ev[2] += (evt_a1_on === 1'b1);
    n_ev[3] += (evt_a1_off === 1'b1);
    n_ev[4] += (evt_a2_on === 1'b1);
    n_ev[5] += (evt_a2_off === 1'b1);
    if (evt_trig === 1'b1)
      t_ev = evt_time;
  end

  task final_report;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat,
           output logic err);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      n_fail++;
      final_report();
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd

  // currents of the three phases differ by one so a swapped phase shows
  task opn(input logic [CUR_W-1:0] ca, input logic [OPS_W-1:0] da, db, dc);
    u_brk.open_breaker(ca, ca + 16'h1, ca + 16'h2, da, db, dc);
  endtask : opn

  initial
  begin
    logic [31:0] r;
    logic        e;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    n_ev = '{default: 0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 10; i++)
      rd(ra[i], rv[i]);
    apb(1'b0, 8'hFC, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(OFF_START, 32'h3F2);
    wr(OFF_IRQ_MASK, 32'h1F);
    wr(OFF_CTRL, 32'h2F);
    opn(16'h0123, 18'h5, 18'hB, 18'h0);
    rd(OFF_LEFT_A, 32'h3ED);
    rd(OFF_LEFT_B, 32'h3E7);
    rd(OFF_LEFT_C, 32'h3F2);
    rd(OFF_STATUS, 32'h5);
    rd(OFF_IRQ_STAT, 32'h3);
    chk({alarm1, alarm2, irq}, 32'h5);
    chk(n_ev[0] + 16 * n_ev[1] + 256 * n_ev[2], 32'h111);
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_STAT, 32'h1F);
    rd(OFF_IRQ_STAT, 32'h0);
    wr(OFF_IRQ_MASK, 32'h1F);
    opn(16'h0200, 18'h0, 18'h384, 18'h0);
    rd(OFF_LEFT_B, 32'h63);
    rd(OFF_STATUS, 32'hE);
    rd(OFF_IRQ_STAT, 32'h9);
    rd(OFF_OPEN_CNT, 32'h2);
    rd(OFF_A1_CNT, 32'h1);
    rd(OFF_A2_CNT, 32'h1);
    chk(n_ev[4], 32'h1);
    rd(OFF_LOG_CNT, 32'h4);
    wr(OFF_LOG_SEL, 32'h0);
    rd(OFF_LOG_BASE + 8'h04, {30'h0, EV_A2_ON});
    rd(OFF_LOG_BASE + 8'h24, 32'h63);
    wr(OFF_LOG_SEL, 32'h1);
    rd(OFF_LOG_BASE + 8'h04, {30'h0, EV_TRIG});
    rd(OFF_LOG_BASE + 8'h0C, 32'h201);
    rd(OFF_LOG_BASE + 8'h18, 32'h384);
    wr(OFF_IRQ_STAT, 32'h1F);
    // reload with only OFF events selected
    wr(OFF_CTRL, 32'h2B);
    repeat (4) @(posedge pclk);
    chk({alarm1, alarm2, irq}, 32'h1);
    rd(OFF_IRQ_STAT, 32'h14);
    rd(OFF_LEFT_A, 32'h3F2);
    rd(OFF_LOG_CNT, 32'h4);
    opn(16'h0300, 18'h0, 18'h0, 18'h0);
    chk(n_ev[0] + 16 * n_ev[1] + 256 * n_ev[3] + 4096 * n_ev[5], 32'h1123);
    wr(OFF_CTRL, 32'hC);
    opn(16'h0400, 18'h7D0, 18'h0, 18'h0);
    rd(OFF_LEFT_A, 32'h0);
    chk({alarm1, alarm2}, 32'h0);
    rd(OFF_STATUS, 32'h0);
    for (i = 0; i < 12; i++)
      opn(16'h1000 + 16'(i), 18'h0, 18'h0, 18'h0);
    rd(OFF_LOG_CNT, 32'hC);
    wr(OFF_LOG_SEL, 32'h0);
    rd(OFF_LOG_BASE + 8'h08, 32'h100B);
    wr(OFF_LOG_SEL, 32'hB);
    rd(OFF_LOG_BASE + 8'h08, 32'h1000);
    // preset clock: stamp may have moved on by one tick before the event
    wr(OFF_TIME, 32'h12345678);
    opn(16'h0500, 18'h0, 18'h0, 18'h0);
    chk({31'h0, (t_ev - 32'h12345678) <= 32'h1}, 32'h1);
    wr(OFF_LOG_SEL, 32'h0);
    apb(1'b0, OFF_LOG_BASE, 32'h0, r, e);
    chk({31'h0, (r - t_ev) <= 32'h1}, 32'h1);
    // zero alarm 2 threshold: phase a at 0 trips alarm 1 only
    wr(OFF_A2_SET, 32'h0);
    rd(OFF_A2_SET, 32'h0);
    wr(OFF_CTRL, 32'h7);
    repeat (3) @(posedge pclk);
    chk({alarm1, alarm2}, 32'h2);
    rd(OFF_A1_CNT, 32'h2);
    wr(OFF_CTRL, 32'h1C);
    rd(OFF_OPEN_CNT, 32'h0);
    rd(OFF_A1_CNT, 32'h0);
    final_report();
  end
endmodule : bwm_top_tb
